// ---- bench/host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module host_model import codec_cfg_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output reg_req_s        req
);
  initial req = '0;

  // one request cycle, raised just after an edge, taken at the next one
  task automatic cyc(input logic [6:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk);
    #1;
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = d;
  endtask

  // released bus shows inverted lines so stale values never look valid
  task automatic idle();
    @(posedge core_clk);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1);
    idle();
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    cyc(a, 8'h00, 1'b0);
    idle();
    q = reg_rdata;
  endtask

  task automatic frac(input logic [13:0] v);
    if (v <= 14'd9999) begin
      cyc(7'h05, v[13:6], 1'b1);
      cyc(7'h06, {v[5:0], 2'b00}, 1'b1);
      idle();
    end
  endtask
endmodule

// ---- bench/test_codec_pll_datapath_config.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_codec_pll_datapath_config;
  import codec_cfg_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic         core_clk, reset, ce, pd, dv, isf;
  reg_req_s     req;
  logic [7:0]   reg_rdata, q;
  logic [13:0]  pll_fraction;
  datapath_s    datapath;
  serial_ctrl_s serial, es;
  logic [5:0]   s;
  logic [2:0]   v;
  int           n_errors, total_checks;
  row_s         rows [5] = '{'{7'h05, 8'h5a, 8'h5a}, '{7'h06, 8'hff, 8'hfc},
                             '{7'h07, 8'h9c, 8'h9c}, '{7'h08, 8'hd4, 8'hd4},
                             '{7'h03, 8'h55, 8'h00}};

  host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .req(req));
  codec_pll_datapath_config dut (.core_clk(core_clk), .reset(reset), .ce(ce), .req(req),
    .codec_powered_down(pd), .dout_valid(dv), .general_pin_one_is_frame_clk(isf),
    .reg_rdata(reg_rdata), .pll_fraction(pll_fraction), .datapath(datapath),
    .serial(serial));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    pd = 1'b0;
    dv = 1'b0;
    isf = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    check({2'h0, pll_fraction}, 16'h0000);
    check({9'h0, datapath}, 16'h0000);
    for (int i = 5; i <= 8; i++) begin
      host.rd(7'(i), q);
      check({8'h0, q}, 16'h0000);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, q);
      check({8'h0, q}, {8'h0, rows[i].e});
    end
    $display("register table test done");
    host.frac(14'd9999);
    settle();
    check({2'h0, pll_fraction}, 16'd9999);
    host.wr(7'h05, 8'h12);
    settle();
    check({2'h0, pll_fraction}, 16'd9999);
    host.frac(14'h048d);
    settle();
    check({2'h0, pll_fraction}, 16'h048d);
    $display("fraction test done");
    // dual rate bits kept equal, reserved bit zero
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      host.wr(7'h07, {v[2], v[2], v[2], v[1:0], v[1:0], 1'b0});
      settle();
      check({9'h0, datapath}, {9'h0, v[2], v[2], v[2], v[1:0], v[1:0]});
    end
    $display("datapath test done");
    for (int i = 0; i < 64; i++) begin
      s = 6'(i);
      pd = s[4];
      dv = s[5];
      isf = s[0] ^ s[3];
      host.wr(7'h08, {s[3:0], 1'b0, s[1], 2'b00});
      settle();
      es.bclk_oe = s[3] & (!s[4] | s[0]);
      es.wclk_oe = s[2] & (!s[4] | s[0]);
      es.general_pin_one_oe = es.wclk_oe & isf;
      es.dout_oe = !s[1] | s[5];
      es.effect_3d_en = s[1];
      check({11'h0, serial}, {11'h0, es});
    end
    $display("serial control test done");
    host.wr(7'h00, 8'h01);
    host.wr(7'h07, 8'h00);
    host.wr(7'h05, 8'hff);
    host.rd(7'h07, q);
    check({8'h0, q}, 16'h0000);
    host.rd(7'h00, q);
    check({8'h0, q}, 16'h0001);
    host.wr(7'h00, 8'h00);
    host.rd(7'h07, q);
    check({8'h0, q}, 16'h00fe);
    host.rd(7'h05, q);
    check({8'h0, q}, 16'h0012);
    check({2'h0, pll_fraction}, 16'h048d);
    $display("page test done");
    // frozen clock enable must swallow the write
    ce = 1'b0;
    host.wr(7'h07, 8'h00);
    ce = 1'b1;
    host.rd(7'h07, q);
    check({8'h0, q}, 16'h00fe);
    $display("clock enable test done");
    // reset in mid-run clears everything, data output driven again after one edge
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    check({2'h0, pll_fraction}, 16'h0000);
    check({9'h0, datapath}, 16'h0000);
    check({11'h0, serial}, 16'h0000);
    @(posedge core_clk);
    #1;
    check({11'h0, serial}, 16'h0002);
    host.rd(7'h07, q);
    check({8'h0, q}, 16'h0000);
    host.rd(7'h00, q);
    check({8'h0, q}, 16'h0000);
    $display("mid-run reset test done");
    report_and_stop();
  end

  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule

// ---- verilog/cfg_byte.sv ----
`timescale 1ns/1ps
module cfg_byte import codec_cfg_pkg::*; #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  logic [7:0] next_q;

  // masked bits keep reset value, so read-only bits never move
  always_comb begin
    next_q = q;
    if (ce && wr_en) begin
      next_q = (q & ~WMASK) | (wdata & WMASK);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ---- verilog/codec_cfg_map.svh ----
`ifndef CODEC_CFG_MAP_SVH
`define CODEC_CFG_MAP_SVH

// register offsets (page 0)
`define OFS_PAGE_SELECT        7'h00
`define OFS_PLL_FRACTION_HIGH  7'h05
`define OFS_PLL_FRACTION_LOW   7'h06
`define OFS_DATAPATH_SETUP     7'h07
`define OFS_SERIAL_PORT_CTRL_A 7'h08

// reset values
`define RST_PAGE_SELECT        1'b0
`define RST_PLL_FRACTION_HIGH  8'h00
`define RST_PLL_FRACTION_LOW   8'h00
`define RST_DATAPATH_SETUP     8'h00
`define RST_SERIAL_PORT_CTRL_A 8'h00

// writable bit masks
`define WMASK_FULL             8'hff
`define WMASK_FRACTION_LOW     8'hfc

// fraction layout
`define FRAC_LOW_MSB           7
`define FRAC_LOW_LSB           2
`define FRAC_WIDTH             14

// datapath setup fields
`define DP_FSREF_BIT           7
`define DP_ADC_DUAL_BIT        6
`define DP_DAC_DUAL_BIT        5
`define DP_LEFT_MSB            4
`define DP_LEFT_LSB            3
`define DP_RIGHT_MSB           2
`define DP_RIGHT_LSB           1

// serial port control a fields
`define SP_BCLK_MASTER_BIT     7
`define SP_WCLK_MASTER_BIT     6
`define SP_DOUT_TRISTATE_BIT   5
`define SP_CLK_KEEP_BIT        4
`define SP_EFFECT_3D_BIT       2

`endif

// ---- verilog/codec_cfg_pkg.sv ----
package codec_cfg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       fsref_44k1;
    logic       adc_dual_rate;
    logic       dac_dual_rate;
    logic [1:0] left_route;
    logic [1:0] right_route;
  } datapath_s;

  typedef struct packed {
    logic bclk_oe;
    logic wclk_oe;
    logic general_pin_one_oe;
    logic dout_oe;
    logic effect_3d_en;
  } serial_ctrl_s;

  typedef struct packed {
    logic                page;
    logic [7:0]          rdata;
    logic [13:0]         fraction;
    datapath_s           datapath;
    serial_ctrl_s        serial;
  } cfg_state_s;

endpackage

// ---- verilog/codec_pll_datapath_config.sv ----
`timescale 1ns/1ps
`include "codec_cfg_map.svh"
module codec_pll_datapath_config import codec_cfg_pkg::*; (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire reg_req_s      req,
  input  wire logic          codec_powered_down,
  input  wire logic          dout_valid,
  input  wire logic          general_pin_one_is_frame_clk,
  output logic      [7:0]    reg_rdata,
  output logic      [13:0]   pll_fraction,
  output datapath_s          datapath,
  output serial_ctrl_s       serial
);

  cfg_state_s state;
  cfg_state_s next_state;
  logic [7:0] frac_high;
  logic [7:0] frac_low;
  logic [7:0] dp_setup;
  logic [7:0] sp_ctrl;
  logic       page0;
  logic       wr_high;
  logic       wr_low;
  logic       wr_dp;
  logic       wr_sp;
  logic       clocks_run;

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  assign page0   = (state.page == 1'b0);
  assign wr_high = req.wr && page0 && (req.addr == `OFS_PLL_FRACTION_HIGH);
  assign wr_low  = req.wr && page0 && (req.addr == `OFS_PLL_FRACTION_LOW);
  assign wr_dp   = req.wr && page0 && (req.addr == `OFS_DATAPATH_SETUP);
  assign wr_sp   = req.wr && page0 && (req.addr == `OFS_SERIAL_PORT_CTRL_A);

  cfg_byte #(
    .RESET_VAL (`RST_PLL_FRACTION_HIGH),
    .WMASK     (`WMASK_FULL)
  ) u_frac_high (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .wr_en    (wr_high),
    .wdata    (req.wdata),
    .q        (frac_high)
  );

  cfg_byte #(
    .RESET_VAL (`RST_PLL_FRACTION_LOW),
    .WMASK     (`WMASK_FRACTION_LOW)
  ) u_frac_low (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .wr_en    (wr_low),
    .wdata    (req.wdata),
    .q        (frac_low)
  );

  cfg_byte #(
    .RESET_VAL (`RST_DATAPATH_SETUP),
    .WMASK     (`WMASK_FULL)
  ) u_dp_setup (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .wr_en    (wr_dp),
    .wdata    (req.wdata),
    .q        (dp_setup)
  );

  // reserved bit 3 is stored as written, the host is trusted to leave it
  cfg_byte #(
    .RESET_VAL (`RST_SERIAL_PORT_CTRL_A),
    .WMASK     (`WMASK_FULL)
  ) u_sp_ctrl (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .wr_en    (wr_sp),
    .wdata    (req.wdata),
    .q        (sp_ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // master clocks stop on power down unless told to keep running
  assign clocks_run = !codec_powered_down || sp_ctrl[`SP_CLK_KEEP_BIT];

  always_comb begin
    next_state = state;
    if (ce) begin
      // page register answers on both pages, otherwise page 0 could never be selected again from page 1
      if (req.wr && (req.addr == `OFS_PAGE_SELECT)) begin
        next_state.page = req.wdata[0];
      end
      // new fraction takes effect only on the low write, never half updated
      if (wr_low) begin
        next_state.fraction = {frac_high,
                               req.wdata[`FRAC_LOW_MSB:`FRAC_LOW_LSB]};
      end
      if (req.rd) begin
        if (req.addr == `OFS_PAGE_SELECT) begin
          next_state.rdata = {7'h00, state.page};
        end else if (!page0) begin
          next_state.rdata = 8'h00;
        end else begin
          case (req.addr)
            `OFS_PLL_FRACTION_HIGH:  next_state.rdata = frac_high;
            `OFS_PLL_FRACTION_LOW:   next_state.rdata = frac_low;
            `OFS_DATAPATH_SETUP:     next_state.rdata = dp_setup;
            `OFS_SERIAL_PORT_CTRL_A: next_state.rdata = sp_ctrl;
            default:                 next_state.rdata = 8'h00;
          endcase
        end
      end
      next_state.datapath.fsref_44k1    = dp_setup[`DP_FSREF_BIT];
      next_state.datapath.adc_dual_rate = dp_setup[`DP_ADC_DUAL_BIT];
      next_state.datapath.dac_dual_rate = dp_setup[`DP_DAC_DUAL_BIT];
      next_state.datapath.left_route    = dp_setup[`DP_LEFT_MSB:`DP_LEFT_LSB];
      next_state.datapath.right_route   = dp_setup[`DP_RIGHT_MSB:`DP_RIGHT_LSB];
      next_state.serial.bclk_oe = sp_ctrl[`SP_BCLK_MASTER_BIT] && clocks_run;
      next_state.serial.wclk_oe = sp_ctrl[`SP_WCLK_MASTER_BIT] && clocks_run;
      next_state.serial.general_pin_one_oe = sp_ctrl[`SP_WCLK_MASTER_BIT]
                                             && clocks_run
                                             && general_pin_one_is_frame_clk;
      next_state.serial.dout_oe = !sp_ctrl[`SP_DOUT_TRISTATE_BIT]
                                  || dout_valid;
      next_state.serial.effect_3d_en = sp_ctrl[`SP_EFFECT_3D_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata    = state.rdata;
  assign pll_fraction = state.fraction;
  assign datapath     = state.datapath;
  assign serial       = state.serial;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_high_store;
    ce && wr_high |=> frac_high == $past(req.wdata);
  endproperty
  a_high_store: assert property (p_high_store)
    else $error("fraction high byte not stored");

  property p_low_reserved;
    frac_low[1:0] == 2'b00;
  endproperty
  a_low_reserved: assert property (p_low_reserved)
    else $error("reserved fraction low bits not zero");

  property p_frac_apply;
    ce && wr_low |=> pll_fraction[13:6] == $past(frac_high)
                     && pll_fraction[5:0] == ($past(req.wdata) >> 2);
  endproperty
  a_frac_apply: assert property (p_frac_apply)
    else $error("fraction not applied after low write");

  property p_frac_hold;
    !(ce && wr_low) |=> $stable(pll_fraction);
  endproperty
  a_frac_hold: assert property (p_frac_hold)
    else $error("fraction changed without low write");

  property p_page_block;
    ce && req.wr && state.page && req.addr == `OFS_PLL_FRACTION_HIGH
      |=> $stable(frac_high);
  endproperty
  a_page_block: assert property (p_page_block)
    else $error("page one write reached page zero register");

  property p_datapath;
    ce |=> {datapath, 1'b0} == ($past(dp_setup) & 8'hfe);
  endproperty
  a_datapath: assert property (p_datapath)
    else $error("datapath outputs differ from setup register");

  property p_bclk;
    ce |=> serial.bclk_oe == ($past(sp_ctrl[7])
                              && (!$past(codec_powered_down) || $past(sp_ctrl[4])));
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("bit clock drive wrong");

  property p_wclk;
    ce ##1 serial.general_pin_one_oe |-> serial.wclk_oe;
  endproperty
  a_wclk: assert property (p_wclk)
    else $error("general pin drives frame clock without master");

  property p_dout;
    ce && sp_ctrl[5] && !dout_valid |=> !serial.dout_oe;
  endproperty
  a_dout: assert property (p_dout)
    else $error("data output not tri-stated while idle");

  property p_effect;
    ce |=> serial.effect_3d_en == $past(sp_ctrl[2]);
  endproperty
  a_effect: assert property (p_effect)
    else $error("effect enable does not follow control bit");

  c_frac_pair: cover property (ce && wr_high ##1 ce && wr_low);
  c_page_one:  cover property (state.page ##1 !state.page);
  c_keep_clk:  cover property (sp_ctrl[7] && sp_ctrl[4] && codec_powered_down ##1 serial.bclk_oe);
  c_tristate:  cover property (ce && sp_ctrl[5] && !dout_valid ##1 !serial.dout_oe);

endmodule
